// ---- design/tnr_pkg.sv ----
package tnr_pkg;
  // Register byte addresses
  localparam logic [7:0] ADR_ICTL = 8'h34;
  localparam logic [7:0] ADR_DCTL = 8'h38;
  localparam logic [7:0] ADR_IVH  = 8'h3c;
  localparam logic [7:0] ADR_STAT = 8'h40;
  // Field positions
  localparam int CTL_TRAP_BIT = 7;
  localparam int CTL_FPOS_BIT = 6;
  localparam int CTL_L0EN_BIT = 0;
  localparam int DCTL_MEN_BIT = 0;
  // Reset values
  localparam logic       L0EN_RST = 1'b1;
  localparam logic       IEF_RST  = 1'b0;
  localparam logic       MEN_RST  = 1'b0;
  localparam logic [7:0] IVH_RST  = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  // Response modes
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  // Restart addresses
  localparam logic [15:0] TRAP_VEC = 16'h0000;
  localparam logic [15:0] NMI_VEC  = 16'h0066;
  localparam logic [15:0] M1_VEC   = 16'h0038;
  // Acknowledge cycle timing: T1, T2, waits, T3
  localparam logic [2:0] ACK_T3_PLAIN = 3'h2;
  localparam logic [2:0] ACK_WAITS    = 3'h2;
  // Sequencer states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_TRAP = 8'h02,
    ST_NMI  = 8'h04,
    ST_ACK  = 8'h08,
    ST_OPCK = 8'h10,
    ST_PUSH = 8'h20,
    ST_VLO  = 8'h40,
    ST_VHI  = 8'h80
  } tnr_state_t;
endpackage

// ---- design/tnr_resp.sv ----
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tnr_resp (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Pins
  input  wire logic        nmi_n_i,
  input  wire logic        level0_request_n_i,
  input  wire logic [7:0]  data_bus_i,
  output logic             instruction_fetch_strobe_n_o,
  output logic             io_enable_strobe_n_o,
  // Core timing and decode
  input  wire logic        sample_slot_i,
  input  wire logic        mcyc_end_i,
  input  wire logic        undef_op_i,
  input  wire logic        undef_third_i,
  input  wire logic        op_illegal_i,
  input  wire logic        op_more_i,
  input  wire logic        enable_interrupts_instruction_i,
  input  wire logic        disable_interrupts_i,
  input  wire logic        return_from_nonmaskable_i,
  input  wire logic        response_mode_select_i,
  input  wire logic [1:0]  response_mode_value_i,
  input  wire logic [15:0] pc_i,
  // Core memory port for vector table reads
  input  wire logic        mem_ack_i,
  input  wire logic [7:0]  mem_data_i,
  output logic             mem_rd_o,
  output logic      [15:0] mem_addr_o,
  // Core sequencing outputs
  output logic             busy_o,
  output logic             push_o,
  output logic      [15:0] push_val_o,
  output logic             jump_o,
  output logic      [15:0] jump_addr_o,
  output logic             op_valid_o,
  output logic      [7:0]  op_o,
  output logic             no_insert_o,
  output logic             dma_master_enable_o
);
  tnr_pkg::tnr_state_t state_reg;
  logic       nmi_s1, nmi_s2, nmi_prev, nmi_latch_reg;
  logic       l0_s1, l0_s2;
  logic [7:0] d_s1, d_s2;
  logic       take_nmi_reg, take_l0_reg;
  logic       global_enable_flag_reg, saved_enable_flag_reg;
  logic       level0_line_enable_reg, trap_flag_reg, fetch_byte_position_flag_reg;
  logic       dma_master_enable_reg;
  logic [1:0] mode_reg;
  logic [7:0] ivh_reg, vec_lo_reg, tbl_lo_reg;
  logic [2:0] cnt_reg;
  logic [2:0] t3_idx;
  logic       st_idle, trap_go, nmi_go, l0_go, ack_t3, op_trap;
  logic       wb_req, wb_wr;

  // Pin synchronisers, two flops each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      l0_s1  <= 1'b1;
      l0_s2  <= 1'b1;
      d_s1   <= 8'h00;
      d_s2   <= 8'h00;
    end else begin
      nmi_s1 <= nmi_n_i;
      nmi_s2 <= nmi_s1;
      l0_s1  <= level0_request_n_i;
      l0_s2  <= l0_s1;
      d_s1   <= data_bus_i;
      d_s2   <= d_s1;
    end
  end

  // Sequencer events; trap outranks everything, then non-maskable, then level 0
  assign st_idle = (state_reg == tnr_pkg::ST_IDLE);
  assign trap_go = st_idle & undef_op_i;
  assign nmi_go  = st_idle & ~undef_op_i & mcyc_end_i & take_nmi_reg;
  assign l0_go   = st_idle & ~undef_op_i & mcyc_end_i & take_l0_reg & ~take_nmi_reg;
  assign t3_idx  = (mode_reg == tnr_pkg::MODE_2) ? tnr_pkg::ACK_T3_PLAIN + tnr_pkg::ACK_WAITS
                                                 : tnr_pkg::ACK_T3_PLAIN;
  assign ack_t3  = (state_reg == tnr_pkg::ST_ACK) && (cnt_reg == t3_idx);
  assign op_trap = (state_reg == tnr_pkg::ST_OPCK) & op_illegal_i;
  assign busy_o  = ~st_idle;

  // Falling-edge latch of the non-maskable request, held until sampled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_prev      <= 1'b1;
      nmi_latch_reg <= 1'b0;
    end else begin
      nmi_prev <= nmi_s2;
      if (nmi_prev & ~nmi_s2)
        nmi_latch_reg <= 1'b1;
      else if (sample_slot_i & st_idle)
        nmi_latch_reg <= 1'b0;
    end
  end

  // Sampling at the slot before T3 or Ti of the last machine cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      take_nmi_reg <= 1'b0;
      take_l0_reg  <= 1'b0;
    end else if (sample_slot_i & st_idle) begin
      take_nmi_reg <= nmi_latch_reg | (nmi_prev & ~nmi_s2);
      take_l0_reg  <= ~l0_s2 & global_enable_flag_reg & level0_line_enable_reg;
    end else if (mcyc_end_i | ~st_idle) begin
      take_nmi_reg <= 1'b0;
      take_l0_reg  <= 1'b0;
    end
  end

  // Global and saved enable flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_enable_flag_reg <= tnr_pkg::IEF_RST;
      saved_enable_flag_reg  <= tnr_pkg::IEF_RST;
    end else if (nmi_go) begin
      saved_enable_flag_reg  <= global_enable_flag_reg;
      global_enable_flag_reg <= 1'b0;
    end else if (l0_go) begin
      saved_enable_flag_reg  <= 1'b0;
      global_enable_flag_reg <= 1'b0;
    end else if (return_from_nonmaskable_i) begin
      global_enable_flag_reg <= saved_enable_flag_reg;
    end else if (enable_interrupts_instruction_i) begin
      global_enable_flag_reg <= 1'b1;
      saved_enable_flag_reg  <= 1'b1;
    end else if (disable_interrupts_i) begin
      global_enable_flag_reg <= 1'b0;
      saved_enable_flag_reg  <= 1'b0;
    end
  end

  // Response mode select
  always_ff @(posedge clk_i) begin
    if (rst_i)
      mode_reg <= tnr_pkg::MODE_RST;
    else if (response_mode_select_i && response_mode_value_i != 2'h3)
      mode_reg <= response_mode_value_i;
  end

  // Wishbone handshake: ack one cycle after the request, dropped after one
  assign wb_req = cyc_i & stb_i & ~ack_o;
  assign wb_wr  = cyc_i & stb_i & ack_o & we_i & sel_i[0]; // Write lands at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= wb_req;
  end

  // Interrupt/trap control register; hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_flag_reg                <= 1'b0;
      fetch_byte_position_flag_reg <= 1'b0;
      level0_line_enable_reg       <= tnr_pkg::L0EN_RST;
    end else begin
      if (trap_go | op_trap) begin
        trap_flag_reg                <= 1'b1;
        fetch_byte_position_flag_reg <= trap_go & undef_third_i;
      end else if (wb_wr && adr_i == tnr_pkg::ADR_ICTL && !dat_i[tnr_pkg::CTL_TRAP_BIT]) begin
        trap_flag_reg <= 1'b0; // Writing one is ignored
      end
      if (wb_wr && adr_i == tnr_pkg::ADR_ICTL)
        level0_line_enable_reg <= dat_i[tnr_pkg::CTL_L0EN_BIT];
    end
  end

  // DMA control and vector high registers; non-maskable entry clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_master_enable_reg <= tnr_pkg::MEN_RST;
      ivh_reg               <= tnr_pkg::IVH_RST;
    end else begin
      if (nmi_go)
        dma_master_enable_reg <= 1'b0;
      else if (wb_wr && adr_i == tnr_pkg::ADR_DCTL)
        dma_master_enable_reg <= dat_i[tnr_pkg::DCTL_MEN_BIT];
      if (wb_wr && adr_i == tnr_pkg::ADR_IVH)
        ivh_reg <= dat_i[7:0];
    end
  end
  assign dma_master_enable_o = dma_master_enable_reg;

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (wb_req & ~we_i) begin
      case (adr_i)
        tnr_pkg::ADR_ICTL: dat_o <= {24'h00_0000, trap_flag_reg, fetch_byte_position_flag_reg,
                                     5'h00, level0_line_enable_reg};
        tnr_pkg::ADR_DCTL: dat_o <= {31'h0000_0000, dma_master_enable_reg};
        tnr_pkg::ADR_IVH:  dat_o <= {24'h00_0000, ivh_reg};
        tnr_pkg::ADR_STAT: dat_o <= {16'h0000, state_reg, 4'h0, mode_reg,
                                     saved_enable_flag_reg, global_enable_flag_reg};
        default:           dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Response sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= tnr_pkg::ST_IDLE;
      cnt_reg     <= 3'h0;
      push_o      <= 1'b0;
      push_val_o  <= 16'h0000;
      jump_o      <= 1'b0;
      jump_addr_o <= 16'h0000;
      op_valid_o  <= 1'b0;
      op_o        <= 8'h00;
      mem_rd_o    <= 1'b0;
      mem_addr_o  <= 16'h0000;
      vec_lo_reg  <= 8'h00;
      tbl_lo_reg  <= 8'h00;
      no_insert_o <= 1'b0;
      instruction_fetch_strobe_n_o <= 1'b1;
      io_enable_strobe_n_o         <= 1'b1;
    end else begin
      push_o      <= 1'b0;
      jump_o      <= 1'b0;
      op_valid_o  <= 1'b0;
      no_insert_o <= (state_reg == tnr_pkg::ST_TRAP);
      case (state_reg)
        tnr_pkg::ST_IDLE: begin
          cnt_reg <= 3'h0;
          if (trap_go) begin
            state_reg <= tnr_pkg::ST_TRAP;
          end else if (nmi_go) begin
            state_reg <= tnr_pkg::ST_NMI;
          end else if (l0_go) begin
            state_reg <= tnr_pkg::ST_ACK;
            instruction_fetch_strobe_n_o <= 1'b0;
            io_enable_strobe_n_o         <= 1'b0;
          end
        end
        tnr_pkg::ST_TRAP: begin
          push_o      <= 1'b1;
          push_val_o  <= pc_i;
          jump_o      <= 1'b1;
          jump_addr_o <= tnr_pkg::TRAP_VEC;
          state_reg   <= tnr_pkg::ST_IDLE;
        end
        tnr_pkg::ST_NMI: begin
          push_o      <= 1'b1;
          push_val_o  <= pc_i;
          jump_o      <= 1'b1;
          jump_addr_o <= tnr_pkg::NMI_VEC;
          state_reg   <= tnr_pkg::ST_IDLE;
        end
        tnr_pkg::ST_ACK: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (ack_t3) begin
            instruction_fetch_strobe_n_o <= 1'b1;
            io_enable_strobe_n_o         <= 1'b1;
            cnt_reg                      <= 3'h0;
            case (mode_reg)
              tnr_pkg::MODE_0: begin
                op_o       <= d_s2;
                op_valid_o <= 1'b1;
                state_reg  <= tnr_pkg::ST_OPCK;
              end
              tnr_pkg::MODE_1: begin
                push_o      <= 1'b1;
                push_val_o  <= pc_i;
                jump_o      <= 1'b1;
                jump_addr_o <= tnr_pkg::M1_VEC;
                state_reg   <= tnr_pkg::ST_IDLE;
              end
              default: begin
                vec_lo_reg <= d_s2;
                state_reg  <= tnr_pkg::ST_PUSH;
              end
            endcase
          end
        end
        tnr_pkg::ST_OPCK: begin
          if (op_illegal_i) begin
            state_reg <= tnr_pkg::ST_TRAP;
          end else if (op_more_i) begin
            state_reg <= tnr_pkg::ST_ACK;
            instruction_fetch_strobe_n_o <= 1'b0;
            io_enable_strobe_n_o         <= 1'b0;
          end else begin
            state_reg <= tnr_pkg::ST_IDLE;
          end
        end
        tnr_pkg::ST_PUSH: begin
          push_o     <= 1'b1;
          push_val_o <= pc_i;
          mem_rd_o   <= 1'b1;
          mem_addr_o <= {ivh_reg, vec_lo_reg};
          state_reg  <= tnr_pkg::ST_VLO;
        end
        tnr_pkg::ST_VLO: begin
          if (mem_ack_i) begin
            tbl_lo_reg <= mem_data_i;
            mem_addr_o <= mem_addr_o + 16'h0001;
            state_reg  <= tnr_pkg::ST_VHI;
          end
        end
        tnr_pkg::ST_VHI: begin
          if (mem_ack_i) begin
            mem_rd_o    <= 1'b0;
            jump_o      <= 1'b1;
            jump_addr_o <= {mem_data_i, tbl_lo_reg};
            state_reg   <= tnr_pkg::ST_IDLE;
          end
        end
        default: state_reg <= tnr_pkg::ST_IDLE;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_TRAP_UNMASKED: assert property (
    trap_go |=> state_reg == tnr_pkg::ST_TRAP ##1 (push_o && jump_o && jump_addr_o == 16'h0000))
    else $error("trap did not restart at zero");
  AST_TRAP_FLAG: assert property (
    (trap_go | op_trap) |=> trap_flag_reg)
    else $error("trap flag not set");
  AST_UFO: assert property (
    trap_go |=> fetch_byte_position_flag_reg == $past(undef_third_i))
    else $error("fetch byte position flag wrong");
  AST_QUIET: assert property (
    state_reg == tnr_pkg::ST_TRAP |=> no_insert_o)
    else $error("insertion not blocked after trap state");
  AST_NMI_ENTRY: assert property (
    nmi_go |=> !dma_master_enable_reg && !global_enable_flag_reg
               && saved_enable_flag_reg == $past(global_enable_flag_reg))
    else $error("non-maskable entry flags wrong");
  AST_NMI_VEC: assert property (
    nmi_go |=> ##1 (jump_o && push_o && jump_addr_o == 16'h0066))
    else $error("non-maskable restart address wrong");
  AST_L0_MASK: assert property (
    (sample_slot_i && st_idle && !(global_enable_flag_reg && level0_line_enable_reg)) |=> !take_l0_reg)
    else $error("level 0 taken while masked");
  AST_PRIO: assert property (
    (mcyc_end_i && st_idle && !undef_op_i && take_nmi_reg) |=> state_reg == tnr_pkg::ST_NMI)
    else $error("level 0 outranked non-maskable");
  AST_M2_WAITS: assert property (
    (l0_go && mode_reg == tnr_pkg::MODE_2)
      |=> (!instruction_fetch_strobe_n_o && !io_enable_strobe_n_o) [*5] ##1 io_enable_strobe_n_o)
    else $error("vector fetch cycle length wrong");
  AST_M1: assert property (
    (l0_go && mode_reg == tnr_pkg::MODE_1) |=> ##3 (jump_o && jump_addr_o == 16'h0038))
    else $error("mode 1 restart address wrong");
  AST_RETURN_FROM_NONMASKABLE: assert property (
    (return_from_nonmaskable_i && st_idle && !nmi_go && !l0_go)
      |=> global_enable_flag_reg == $past(saved_enable_flag_reg))
    else $error("return did not restore global flag");
endmodule // tnr_resp
`default_nettype wire

// ---- testbench/tnr_irq_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module tnr_irq_dev (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench control
  input  wire logic       raise_i,
  input  wire logic [7:0] resp_i,
  // Acknowledge strobes from the block
  input  wire logic       instruction_fetch_strobe_n_i,
  input  wire logic       io_enable_strobe_n_i,
  // Request and data pins
  output logic            level0_request_n_o,
  output logic      [7:0] data_bus_o
);
  logic ack_seen;
  logic pend_reg;

  // Both strobes low mark our acknowledge cycle
  assign ack_seen = !instruction_fetch_strobe_n_i && !io_enable_strobe_n_i;

  // Request stays low until the block acknowledges it
  always_ff @(posedge clk_i) begin
    if (rst_i || ack_seen) begin
      pend_reg <= 1'b0;
    end else if (raise_i) begin
      pend_reg <= 1'b1;
    end
  end
  assign level0_request_n_o = !pend_reg;

  // Response byte while pending or acknowledged; toggling junk when released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_bus_o <= 8'h00;
    end else if (pend_reg || ack_seen || raise_i) begin
      data_bus_o <= resp_i;
    end else begin
      data_bus_o <= ~data_bus_o;
    end
  end
endmodule  // tnr_irq_dev
`default_nettype wire

// ---- testbench/tnr_resp_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tnr_resp_tb;
  // Stimulus and observed signals
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00, dbus, op, last_op, resp = 8'h00, mdat = 8'h00;
  logic [31:0] wdat = 32'h0, dat, rd;
  logic [6:0]  pv = 7'h00;
  logic [1:0]  mval = 2'h0;
  logic [15:0] pc = 16'h0000, maddr, push_val, jump_addr, last_push, last_jump;
  logic        nmi_n = 1'b1, req_n, ifs_n, ioe_n, third = 1'b0, illegal = 1'b0, mack = 1'b0;
  logic        mem_rd, busy, push, jump, op_valid, noins, dma_master_enable, raise = 1'b0, more = 1'b0;
  int          mismatches = 0, checks = 0, cyc_cnt = 0, push_n, jump_n, op_n, strobe_n;
  int          noins_cyc, jump_cyc, m1_len;

  tnr_resp tnr_resp_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'h1), .dat_i(wdat), .dat_o(dat), .ack_o(ack), .nmi_n_i(nmi_n),
    .level0_request_n_i(req_n), .data_bus_i(dbus), .instruction_fetch_strobe_n_o(ifs_n),
    .io_enable_strobe_n_o(ioe_n), .sample_slot_i(pv[0]), .mcyc_end_i(pv[1]),
    .undef_op_i(pv[2]), .undef_third_i(third), .op_illegal_i(illegal), .op_more_i(more),
    .enable_interrupts_instruction_i(pv[3]), .disable_interrupts_i(pv[4]),
    .return_from_nonmaskable_i(pv[5]), .response_mode_select_i(pv[6]),
    .response_mode_value_i(mval), .pc_i(pc), .mem_ack_i(mack), .mem_data_i(mdat),
    .mem_rd_o(mem_rd), .mem_addr_o(maddr), .busy_o(busy), .push_o(push),
    .push_val_o(push_val), .jump_o(jump), .jump_addr_o(jump_addr), .op_valid_o(op_valid),
    .op_o(op), .no_insert_o(noins), .dma_master_enable_o(dma_master_enable)
  );

  tnr_irq_dev tnr_irq_dev_inst (
    .clk_i(clk_i), .rst_i(rst_i), .raise_i(raise), .resp_i(resp),
    .instruction_fetch_strobe_n_i(ifs_n), .io_enable_strobe_n_i(ioe_n),
    .level0_request_n_o(req_n), .data_bus_o(dbus)
  );

  // Clock at 10 MHz
  always #50 clk_i = ~clk_i;

  // Log sequencer pulses and acknowledge strobes each cycle
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (push === 1'b1) begin
      push_n++;
      last_push = push_val;
    end
    if (jump === 1'b1) begin
      jump_n++;
      last_jump = jump_addr;
      jump_cyc = cyc_cnt;
    end
    if (op_valid === 1'b1) begin
      op_n++;
      last_op = op;
    end
    if (noins === 1'b1) noins_cyc = cyc_cnt;
    if (ifs_n === 1'b0 && ioe_n === 1'b0) strobe_n++;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Register read with comparison
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // One-cycle core pulse: 0 slot, 1 cycle end, 2 undefined, 3 enable, 4 disable, 5 return, 6 mode
  task automatic pulse(input int k);
    @(posedge clk_i);
    pv <= 7'h01 << k;
    @(posedge clk_i);
    pv <= 7'h00;
  endtask

  // Sampling slot followed by the machine cycle end
  task automatic take();
    pulse(0);
    pulse(1);
  endtask

  // Forget earlier pulses
  task automatic clr();
    @(negedge clk_i);
    push_n = 0;
    jump_n = 0;
    op_n = 0;
    strobe_n = 0;
  endtask

  // Wait for a restart or opcode hand-off, then let the sequence finish
  task automatic wait_done();
    for (int i = 0; i < 60 && jump_n == 0 && op_n == 0; i++) @(negedge clk_i);
    repeat (6) @(negedge clk_i);
  endtask

  // Partner raises level 0 with a response byte; allow for the synchronisers
  task automatic req(input logic [7:0] b);
    @(posedge clk_i);
    resp <= b;
    raise <= 1'b1;
    @(posedge clk_i);
    raise <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Select a response mode
  task automatic mode(input logic [1:0] m);
    @(posedge clk_i);
    mval <= m;
    pulse(6);
  endtask

  // Register state after reset and an unmapped place
  task automatic t_reset();
    rdc(tnr_pkg::ADR_ICTL, 32'h01);
    rdc(tnr_pkg::ADR_STAT, 32'h0100);
    rdc(tnr_pkg::ADR_IVH, 32'h0);
    wb(1'b1, 8'h50, 32'hff);
    rdc(8'h50, 32'h0);
    check(busy, 1'b0);
  endtask

  // Undefined third byte while interrupts are disabled
  task automatic t_trap();
    clr();
    @(posedge clk_i);
    pc <= 16'h1234;
    third <= 1'b1;
    pulse(2);
    wait_done();
    check(push_n, 1);
    check(last_push, 16'h1234);
    check(last_jump, tnr_pkg::TRAP_VEC);
    check(noins_cyc, jump_cyc);
    rdc(tnr_pkg::ADR_ICTL, 32'hc1);
    wb(1'b1, tnr_pkg::ADR_ICTL, 32'h01);
    wb(1'b1, tnr_pkg::ADR_ICTL, 32'h81);
    wb(1'b0, tnr_pkg::ADR_ICTL, 32'h0);
    check(rd & 32'h81, 32'h01);
  endtask

  // Short falling pulse during DMA, then return and a retry with no new edge
  task automatic t_nmi();
    wb(1'b1, tnr_pkg::ADR_DCTL, 32'h1);
    @(negedge clk_i);
    check(dma_master_enable, 1'b1);
    pulse(3);
    clr();
    @(posedge clk_i) nmi_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    nmi_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    take();
    wait_done();
    check(jump_n, 1);
    check(last_jump, tnr_pkg::NMI_VEC);
    check(last_push, 16'h1234);
    check(dma_master_enable, 1'b0);
    rdc(tnr_pkg::ADR_STAT, 32'h0102);
    pulse(5);
    rdc(tnr_pkg::ADR_STAT, 32'h0103);
    clr();
    take();
    repeat (20) @(negedge clk_i);
    check(jump_n, 0);
  endtask

  // Both requests at once, then level 0 in mode 1
  task automatic t_prio();
    mode(tnr_pkg::MODE_1);
    @(posedge clk_i) nmi_n <= 1'b0;
    req(8'hff);
    nmi_n <= 1'b1;
    clr();
    take();
    wait_done();
    check(last_jump, tnr_pkg::NMI_VEC);
    check(strobe_n, 0);
    pulse(5);
    clr();
    take();
    wait_done();
    check(last_jump, tnr_pkg::M1_VEC);
    check(push_n, 1);
    m1_len = strobe_n;
    rdc(tnr_pkg::ADR_STAT, 32'h0104);
  endtask

  // Global flag off, then line enable off, then both on
  task automatic t_mask();
    pulse(3);
    pulse(4);
    req(8'h00);
    clr();
    take();
    repeat (20) @(negedge clk_i);
    check({busy, jump_n[0]}, 2'b00);
    pulse(3);
    wb(1'b1, tnr_pkg::ADR_ICTL, 32'h00);
    take();
    repeat (20) @(negedge clk_i);
    check(jump_n, 0);
    wb(1'b1, tnr_pkg::ADR_ICTL, 32'h01);
    take();
    wait_done();
    check(last_jump, tnr_pkg::M1_VEC);
  endtask

  // Mode 0: a legal opcode, then an invalid one
  task automatic t_mode0();
    mode(tnr_pkg::MODE_0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i) illegal <= k[0];
      pulse(3);
      req(8'hc7 + k[7:0]);
      clr();
      take();
      wait_done();
      check({op_n[1:0], last_op}, {2'h1, 8'hc7 + k[7:0]});
      check(push_n, k);
    end
    check(last_jump, tnr_pkg::TRAP_VEC);
    wb(1'b0, tnr_pkg::ADR_ICTL, 32'h0);
    check(rd & 32'h80, 32'h80);
    illegal <= 1'b0;
    // Two-byte response: partner keeps its byte up while the core asks for more
    pulse(3);
    resp <= 8'h3e;
    raise <= 1'b1;
    more <= 1'b1;
    repeat (4) @(posedge clk_i);
    clr();
    take();
    @(posedge clk_i iff op_valid === 1'b1);
    more <= 1'b0;
    wait_done();
    raise <= 1'b0;
    check({op_n[1:0], last_op}, {2'h2, 8'h3e});
    check(push_n, 0);
    check(strobe_n, 2 * m1_len);
  endtask

  // Mode 2: vector low from the bus, table entry low byte first
  task automatic t_mode2();
    wb(1'b1, tnr_pkg::ADR_IVH, 32'h12);
    mode(tnr_pkg::MODE_2);
    pulse(3);
    req(8'h40);
    clr();
    take();
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_i);
      while (mem_rd !== 1'b1) @(negedge clk_i);
      check(maddr, 16'h1240 + k);
      @(posedge clk_i);
      mack <= 1'b1;
      mdat <= k ? 8'hab : 8'hcd;
      @(posedge clk_i);
      mack <= 1'b0;
    end
    wait_done();
    check(last_jump, 16'habcd);
    check(strobe_n, m1_len + 2);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_trap();
    t_nmi();
    t_prio();
    t_mask();
    t_mode0();
    t_mode2();
    summarize();
  end

  // Hang guard, far beyond the expected run
  initial begin
    #500000;
    mismatches++;
    summarize();
  end
endmodule  // tnr_resp_tb
`default_nettype wire
